// *** bcl_pkg.sv ***
/*
  bcl_pkg: shared constants and types of the branch condition and loop unit.
  Assumes the decode stage supplies condition codes and op kinds in these encodings.
*/
package bcl_pkg;

  // branch kinds delivered by decode; alias names share one code
  typedef enum logic [2:0] {
    BCL_OP_NONE,
    BCL_OP_COND,
    BCL_OP_CNT_ZERO,
    BCL_OP_LOOP,
    BCL_OP_LOOP_EQ,
    BCL_OP_LOOP_NE
  } bcl_op_t;

  // condition code: bit 0 negates, bits 3:1 pick the test
  localparam logic [3:0] BCL_CC_OVERFLOW   = 4'h0;
  localparam logic [3:0] BCL_CC_CARRY      = 4'h2;
  localparam logic [3:0] BCL_CC_ZERO       = 4'h4;
  localparam logic [3:0] BCL_CC_BELOW_EQ   = 4'h6;
  localparam logic [3:0] BCL_CC_SIGN       = 4'h8;
  localparam logic [3:0] BCL_CC_PARITY     = 4'hA;
  localparam logic [3:0] BCL_CC_LESS       = 4'hC;
  localparam logic [3:0] BCL_CC_LESS_EQ    = 4'hE;
  localparam int         BCL_CC_NEG_BIT    = 0;

  // bit positions of the flags inside status_word
  localparam int BCL_FLAG_CARRY    = 0;
  localparam int BCL_FLAG_ZERO     = 1;
  localparam int BCL_FLAG_SIGN     = 2;
  localparam int BCL_FLAG_OVERFLOW = 3;
  localparam int BCL_FLAG_PARITY   = 4;

  // address size selector for the count register
  typedef enum logic [1:0] {
    BCL_ASZ_16,
    BCL_ASZ_32,
    BCL_ASZ_64
  } bcl_asz_t;

  localparam int BCL_IP_W   = 64;
  localparam int BCL_DISP_W = 32;
  localparam int BCL_W16    = 16;
  localparam int BCL_W32    = 32;

  localparam logic [63:0] BCL_RST_IP    = 64'h0000_0000_0000_0000;
  localparam logic [63:0] BCL_RST_COUNT = 64'h0000_0000_0000_0000;
  localparam logic [63:0] BCL_ONE       = 64'h0000_0000_0000_0001;
  localparam logic [63:0] BCL_MASK16    = 64'h0000_0000_0000_FFFF;
  localparam logic [63:0] BCL_MASK32    = 64'h0000_0000_FFFF_FFFF;

endpackage

// *** bcl_flag_if.sv ***
/*
  bcl_flag_if: carries the resolved status flags between the top and the
  condition evaluator. Assumes both ends run on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface bcl_flag_if;
  logic carry_flag;
  logic zero_flag;
  logic sign_flag;
  logic overflow_flag;
  logic parity_flag;
  modport src (output carry_flag, zero_flag, sign_flag, overflow_flag, parity_flag);
  modport dst (input  carry_flag, zero_flag, sign_flag, overflow_flag, parity_flag);
endinterface
`default_nettype wire

// *** bcl_cond_eval.sv ***
/*
  bcl_cond_eval: combinational test of one condition code against the flags.
  Assumes flags arrive already forwarded from the youngest older writer.
*/
`timescale 1ns/1ps
`default_nettype none
module bcl_cond_eval
  import bcl_pkg::*;
(
  // condition and flags
  input  wire logic [3:0] cond_code,
  bcl_flag_if.dst         flags,
  // result
  output logic            cond_true
);
  logic base;

  always_comb begin
    unique case ({cond_code[3:1], 1'b0})
      BCL_CC_OVERFLOW: base = flags.overflow_flag;                        // RULE4
      BCL_CC_CARRY:    base = flags.carry_flag;                           // RULE2
      BCL_CC_ZERO:     base = flags.zero_flag;                            // RULE4
      BCL_CC_BELOW_EQ: base = flags.carry_flag | flags.zero_flag;         // RULE1 RULE3
      BCL_CC_SIGN:     base = flags.sign_flag;                            // RULE4
      BCL_CC_PARITY:   base = flags.parity_flag;                          // RULE4
      BCL_CC_LESS:     base = flags.sign_flag ^ flags.overflow_flag;      // RULE6
      default:         base = (flags.sign_flag ^ flags.overflow_flag)
                              | flags.zero_flag;                          // RULE5 RULE7
    endcase
    // negated form only flips the sense; alias names never get own codes
    cond_true = base ^ cond_code[BCL_CC_NEG_BIT];                         // RULE10
  end
endmodule
`default_nettype wire

// *** bcl_count_unit.sv ***
/*
  bcl_count_unit: decrement and zero test of the count register at the
  selected address size. Assumes upper bits outside the size are preserved.
*/
`timescale 1ns/1ps
`default_nettype none
module bcl_count_unit
  import bcl_pkg::*;
(
  // inputs
  input  wire logic [63:0] count_in,
  input  wire bcl_pkg::bcl_asz_t asz,
  // results
  output logic [63:0]      count_dec,
  output logic             count_zero,
  output logic             dec_zero
);
  function automatic logic [63:0] size_mask(input bcl_asz_t a);
    unique case (a)
      BCL_ASZ_16: size_mask = BCL_MASK16;
      BCL_ASZ_32: size_mask = BCL_MASK32;
      default:    size_mask = ~64'h0000_0000_0000_0000;
    endcase
  endfunction

  logic [63:0] m;
  logic [63:0] d;

  always_comb begin
    m          = size_mask(asz);                                          // RULE20
    // wraps zero to all ones within the active width
    d          = count_in - BCL_ONE;                                      // RULE12 RULE14
    count_dec  = (count_in & ~m) | (d & m);                               // RULE12
    count_zero = ((count_in & m) == 64'h0000_0000_0000_0000);             // RULE11
    dec_zero   = ((d & m) == 64'h0000_0000_0000_0000);                    // RULE13
  end
endmodule
`default_nettype wire

// *** bcl_top.sv ***
/*
  bcl_top: resolves conditional branches, count-zero branches and counted
  loops; registers the next instruction pointer, count and taken result.
  Assumes decode gives op, condition, displacement, instruction length and
  mode; flags and count come from the pipeline with a writeback bypass.
*/
// Function
// (RULE1) above: carry and zero both clear
// (RULE2) carry clear or set tests
// (RULE3) below or equal: carry or zero
// (RULE4) single flag tests, plain or negated
// (RULE5) greater: zero clear, sign equals overflow
// (RULE6) sign xor overflow for ge and less
// (RULE7) less or equal: zero or sign differs
// (RULE8) not taken falls through, no return
// (RULE9) target is ip plus signed offset
// (RULE10) alias names share one encoding
// (RULE11) count zero branch tests count register
// (RULE12) loop decrements before test, width by size
// (RULE13) nonzero count jumps, zero falls through
// (RULE14) zero count wraps to all ones
// (RULE15) while equal needs nonzero and zero flag
// (RULE16) while unequal needs nonzero, zero clear
// (RULE17) long mode near branch 64-bit pointer
// (RULE18) long mode ignores operand size prefix
// (RULE19) displacement stays 32 bits, size not forced
// (RULE20) address size picks count width
// (RULE21) use newest older flags and count
`timescale 1ns/1ps
`default_nettype none
module bcl_top
  import bcl_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // branch request from decode
  input  wire logic              br_valid,
  input  wire bcl_pkg::bcl_op_t  br_op,
  input  wire logic [3:0]        br_cond,
  input  wire logic [31:0]       br_disp,
  input  wire logic [3:0]        br_len,
  input  wire logic [63:0]       instr_pointer64,
  // mode and prefixes
  input  wire logic              long_mode,
  input  wire logic              opsize_prefix,
  input  wire logic              addr_prefix,
  input  wire logic              code_32,
  // architectural state from the pipeline
  input  wire logic [4:0]        status_word,
  input  wire logic [63:0]       count_reg64,
  // bypass from an older writer in flight
  input  wire logic              fwd_flags_valid,
  input  wire logic [4:0]        fwd_flags,
  input  wire logic              fwd_count_valid,
  input  wire logic [63:0]       fwd_count,
  input  wire logic              older_pending,
  // results
  output logic                   br_stall,
  output logic                   res_valid,
  output logic                   res_taken,
  output logic [63:0]            res_next_ip,
  output logic                   res_count_we,
  output logic [63:0]            res_count,
  output logic                   res_push_ret,
  output logic                   res_far
);
  typedef struct packed {
    logic        valid;
    logic        taken;
    logic [63:0] next_ip;
    logic        count_we;
    logic [63:0] count;
  } bcl_state_t;

  bcl_state_t st_ff;
  bcl_state_t nxt_st;

  bcl_flag_if flag_bus ();

  logic [4:0]  flags_now;
  logic [63:0] count_now;
  logic        cond_true;
  logic [63:0] count_dec;
  logic        count_zero;
  logic        dec_zero;
  bcl_asz_t    asz;
  logic [63:0] seq_ip;
  logic [63:0] tgt_ip;
  logic [63:0] ip_mask;
  logic        go;

  // bypass beats the architectural copy; stall when the writer is unresolved
  assign flags_now = fwd_flags_valid ? fwd_flags : status_word;           // RULE21
  assign count_now = fwd_count_valid ? fwd_count : count_reg64;           // RULE21
  assign br_stall  = br_valid && (br_op != BCL_OP_NONE) && older_pending; // RULE21
  assign go        = br_valid && !br_stall;

  // flag order in status_word: {parity, overflow, sign, zero, carry}
  assign flag_bus.carry_flag    = flags_now[BCL_FLAG_CARRY];
  assign flag_bus.zero_flag     = flags_now[BCL_FLAG_ZERO];
  assign flag_bus.sign_flag     = flags_now[BCL_FLAG_SIGN];
  assign flag_bus.overflow_flag = flags_now[BCL_FLAG_OVERFLOW];
  assign flag_bus.parity_flag   = flags_now[BCL_FLAG_PARITY];

  bcl_cond_eval u_cond (
    .cond_code (br_cond),
    .flags     (flag_bus),
    .cond_true (cond_true)
  );

  bcl_count_unit u_count (
    .count_in   (count_now),
    .asz        (asz),
    .count_dec  (count_dec),
    .count_zero (count_zero),
    .dec_zero   (dec_zero)
  );

  always_comb begin
    // address size is default 64 in long mode, prefix drops it to 32
    if (long_mode) begin
      asz = addr_prefix ? BCL_ASZ_32 : BCL_ASZ_64;                        // RULE20 RULE19
    end else if (code_32) begin
      asz = addr_prefix ? BCL_ASZ_16 : BCL_ASZ_32;                        // RULE20
    end else begin
      asz = addr_prefix ? BCL_ASZ_32 : BCL_ASZ_16;                        // RULE12
    end
    // pointer width: long mode ignores operand prefix entirely
    if (long_mode) begin
      ip_mask = ~64'h0000_0000_0000_0000;                                 // RULE17 RULE18
    end else if (code_32 ^ opsize_prefix) begin
      ip_mask = BCL_MASK32;
    end else begin
      ip_mask = BCL_MASK16;
    end
  end

  // displacement is sign extended from 32 bits only
  assign seq_ip = (instr_pointer64 + {60'h0, br_len}) & ip_mask;          // RULE8
  assign tgt_ip = (seq_ip + {{(BCL_IP_W-BCL_DISP_W){br_disp[31]}}, br_disp})
                  & ip_mask;                                              // RULE9 RULE19

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.valid    = go && (br_op != BCL_OP_NONE);
    nxt_st.taken    = 1'b0;
    nxt_st.count_we = 1'b0;
    nxt_st.count    = count_now;
    if (go) begin
      unique case (br_op)
        BCL_OP_COND:     nxt_st.taken = cond_true;                        // RULE1 RULE2
        BCL_OP_CNT_ZERO: nxt_st.taken = count_zero;                       // RULE11
        BCL_OP_LOOP: begin
          nxt_st.count_we = 1'b1;                                         // RULE12
          nxt_st.count    = count_dec;                                    // RULE14
          nxt_st.taken    = !dec_zero;                                    // RULE13
        end
        BCL_OP_LOOP_EQ: begin
          nxt_st.count_we = 1'b1;
          nxt_st.count    = count_dec;
          nxt_st.taken    = !dec_zero && flag_bus.zero_flag;              // RULE15
        end
        BCL_OP_LOOP_NE: begin
          nxt_st.count_we = 1'b1;
          nxt_st.count    = count_dec;
          nxt_st.taken    = !dec_zero && !flag_bus.zero_flag;             // RULE16
        end
        default: nxt_st.taken = 1'b0;
      endcase
      if (br_op != BCL_OP_NONE) begin
        nxt_st.next_ip = nxt_st.taken ? tgt_ip : seq_ip;                  // RULE8 RULE13
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '{valid: 1'b0, taken: 1'b0, next_ip: BCL_RST_IP,
                 count_we: 1'b0, count: BCL_RST_COUNT};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign res_valid    = st_ff.valid;
  assign res_taken    = st_ff.taken;
  assign res_next_ip  = st_ff.next_ip;
  assign res_count_we = st_ff.count_we;
  assign res_count    = st_ff.count;
  // conditional transfers never push and are always near
  assign res_push_ret = 1'b0;                                             // RULE8
  assign res_far      = 1'b0;                                             // RULE9
endmodule
`default_nettype wire

// *** bcl_top_checker.sv ***
/* bcl_top_checker: port-level assertions for bcl_top.
   Assumes one clock, sync reset, bound onto bcl_top by name. */
`timescale 1ns/1ps
`default_nettype none
module bcl_top_checker
  import bcl_pkg::*;
(
  // clock, reset, request and state
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              br_valid,
  input wire bcl_pkg::bcl_op_t  br_op,
  input wire logic [3:0]        br_cond,
  input wire logic [31:0]       br_disp,
  input wire logic [3:0]        br_len,
  input wire logic [63:0]       instr_pointer64,
  input wire logic              long_mode,
  input wire logic              addr_prefix,
  input wire logic [4:0]        status_word,
  input wire logic [63:0]       count_reg64,
  input wire logic              fwd_flags_valid,
  input wire logic [4:0]        fwd_flags,
  input wire logic              fwd_count_valid,
  input wire logic [63:0]       fwd_count,
  input wire logic              older_pending,
  // results
  input wire logic              br_stall,
  input wire logic              res_valid,
  input wire logic              res_taken,
  input wire logic [63:0]       res_next_ip,
  input wire logic              res_count_we,
  input wire logic [63:0]       res_count,
  input wire logic              res_push_ret,
  input wire logic              res_far
);
  import bcl_pkg::*;
  logic        acc, ccok, lpok, lp64;
  logic [4:0]  f;
  logic [7:0]  t;
  logic [63:0] seq, tgt, cnt;
  assign acc = br_valid && br_op != BCL_OP_NONE && !older_pending;
  assign f = fwd_flags_valid ? fwd_flags : status_word;
  assign cnt = fwd_count_valid ? fwd_count : count_reg64;
  assign seq = instr_pointer64 + {60'h0, br_len};
  assign tgt = seq + {{32{br_disp[31]}}, br_disp};
  // test per bits 3:1 of the code; bit 0 negates
  assign t = {(f[2] ^ f[3]) | f[1], f[2] ^ f[3], f[4], f[2], f[0] | f[1], f[1], f[0], f[3]};
  assign ccok = t[br_cond[3:1]] ^ br_cond[0];
  assign lpok = br_op == BCL_OP_LOOP || (br_op == BCL_OP_LOOP_EQ && f[1])
             || (br_op == BCL_OP_LOOP_NE && !f[1]);
  assign lp64 = acc && long_mode && !addr_prefix
             && br_op inside {BCL_OP_LOOP, BCL_OP_LOOP_EQ, BCL_OP_LOOP_NE};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_stall_when_older: assert property (
    br_stall == (br_valid && br_op != BCL_OP_NONE && older_pending))
    else $error("stall does not follow pending writer");
  a_one_answer: assert property (acc |=> res_valid)
    else $error("accepted request gave no result");
  a_refused_silent: assert property (!acc |=> !res_valid && !res_count_we)
    else $error("result without accepted request");
  a_never_push: assert property (!res_push_ret && !res_far)
    else $error("return push or far transfer raised");
  a_cond_taken: assert property (
    acc && br_op == BCL_OP_COND |=> res_taken == $past(ccok))
    else $error("condition result wrong");
  a_cond_next_ip: assert property (
    acc && br_op == BCL_OP_COND && long_mode
    |=> res_next_ip == (res_taken ? $past(tgt) : $past(seq))) else $error("next ip wrong");
  a_loop_count: assert property (
    lp64 |=> res_count_we && res_count == $past(cnt) - 64'h1)
    else $error("loop count not decremented");
  a_loop_taken: assert property (
    lp64 |=> res_taken == ($past(cnt) != 64'h1 && $past(lpok)))
    else $error("loop decision wrong");
  a_cntz_low32: assert property (
    acc && br_op == BCL_OP_CNT_ZERO && long_mode && addr_prefix
    |=> res_taken == ($past(cnt[31:0]) == 32'h0)) else $error("count zero test wrong");
  c_loop_eq: cover property (acc && br_op == BCL_OP_LOOP_EQ);
  c_stall: cover property (br_stall);
  c_cntz: cover property (acc && br_op == BCL_OP_CNT_ZERO);
endmodule
bind bcl_top bcl_top_checker u_chk (.*);
`default_nettype wire

// *** bcl_pipe_model.sv ***
/* bcl_pipe_model: pipeline side holding the architectural count.
   Assumes the bench loads it; loop results write back next edge. */
`timescale 1ns/1ps
`default_nettype none
module bcl_pipe_model
  import bcl_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rst,
  input wire logic         load,
  input wire logic [63:0]  load_val,
  input wire logic         res_count_we,
  input wire logic [63:0]  res_count,
  output logic [63:0]      count_reg64
);
  import bcl_pkg::*;
  // no bypass here: the bench leaves a gap so the next loop sees this write
  always_ff @(posedge sys_clk) begin
    if (rst) count_reg64 <= BCL_RST_COUNT;
    else if (load) count_reg64 <= load_val;
    else if (res_count_we) count_reg64 <= res_count;
  end
endmodule
`default_nettype wire

// *** bcl_top_tb.sv ***
/* bcl_top_tb: directed tests of bcl_top through its request port.
   Assumes the pipe model supplies the count for loop tests. */
`timescale 1ns/1ps
`default_nettype none
module bcl_top_tb;
  import bcl_pkg::*;
  logic sys_clk, rst, br_valid, long_mode, opsize_prefix, addr_prefix, code_32, ld;
  logic fwd_flags_valid, fwd_count_valid, older_pending, br_stall, res_valid, res_taken;
  logic res_count_we, res_push_ret, res_far;
  bcl_op_t br_op;
  logic [3:0] br_cond, br_len;
  logic [31:0] br_disp;
  logic [4:0] status_word, fwd_flags, fl;
  logic exp_t;
  logic [63:0] exp_ip;
  logic [63:0] instr_pointer64, fwd_count, ld_val, count_reg64, res_next_ip, res_count;
  int err_count, n_compared;
  bcl_top uut (.*);
  bcl_pipe_model pm (.sys_clk, .rst, .load(ld), .load_val(ld_val), .res_count_we,
                     .res_count, .count_reg64);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic issue(bcl_op_t op, logic [3:0] cc);
    @(posedge sys_clk);
    #1 br_valid = 1'b1;
    br_op = op;
    br_cond = cc;
    @(posedge sys_clk);
    #1 br_valid = 1'b0;
    chk("valid", res_valid, 64'h1);
  endtask
  function automatic logic ref_cc(logic [3:0] cc, logic [4:0] w);
    logic [7:0] r;
    r = {(w[2] ^ w[3]) | w[1], w[2] ^ w[3], w[4], w[2], w[0] | w[1], w[1], w[0], w[3]};
    return r[cc[3:1]] ^ cc[0];
  endfunction
  // taken target FFFF_FFF2 or sequential 1_0000_0012, cut to the ip width
  task automatic cz(logic lm, logic ap, logic c32, logic [63:0] cnt, logic t);
    logic [63:0] m;
    logic [63:0] e;
    m = lm ? 64'hFFFF_FFFF_FFFF_FFFF : (c32 ? BCL_MASK32 : BCL_MASK16);
    e = (t ? 64'h0000_0000_FFFF_FFF2 : 64'h0000_0001_0000_0012) & m;
    {long_mode, addr_prefix, code_32, fwd_count_valid, fwd_count} = {lm, ap, c32, 1'b1, cnt};
    issue(BCL_OP_CNT_ZERO, 4'h0);
    chk("cz_taken", res_taken, t);
    chk("cz_ip", res_next_ip, e);
  endtask
  task automatic load(logic [63:0] v);
    @(posedge sys_clk);
    #1 {ld, ld_val} = {1'b1, v};
    @(posedge sys_clk);
    #1 ld = 1'b0;
  endtask
  task automatic lp(bcl_op_t op, logic zf, logic [63:0] c, logic t);
    status_word = {3'h0, zf, 1'b0};
    issue(op, 4'h0);
    chk("lp_we", res_count_we, 64'h1);
    chk("lp_count", res_count, c);
    chk("lp_taken", res_taken, t);
  endtask
  initial begin
    {br_valid, long_mode, opsize_prefix, addr_prefix, code_32, ld} = 6'h00;
    {fwd_flags_valid, fwd_count_valid, older_pending, rst} = 4'h1;
    {br_cond, br_len, br_disp, status_word, fwd_flags, fwd_count, ld_val} = '0;
    br_op = BCL_OP_NONE;
    instr_pointer64 = 64'h0000_0001_0000_0010;
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    chk("rst_ip", res_next_ip, 64'h0);
    {long_mode, opsize_prefix, br_len, br_disp} = {2'h3, 4'h2, 32'hFFFF_FFE0};
    for (int i = 0; i < 1024; i++) begin
      {fwd_flags_valid, br_cond, fl} = i[9:0];
      status_word = fwd_flags_valid ? ~fl : fl;
      fwd_flags = ~status_word;
      issue(BCL_OP_COND, br_cond);
      exp_t  = ref_cc(br_cond, fl);
      exp_ip = exp_t ? 64'h0000_0000_FFFF_FFF2 : 64'h0000_0001_0000_0012;
      chk("cc_taken", res_taken, exp_t);
      chk("cc_ip", res_next_ip, exp_ip);
      chk("no_push", {res_push_ret, res_far}, 64'h0);
    end
    $display("test conditions done");
    {fwd_flags_valid, opsize_prefix} = 2'h0;
    cz(1'b1, 1'b0, 1'b0, 64'h0000_0001_0000_0000, 1'b0);
    cz(1'b1, 1'b1, 1'b0, 64'h0000_0001_0000_0000, 1'b1);
    cz(1'b0, 1'b0, 1'b1, 64'hFFFF_FFFF_0000_0000, 1'b1);
    cz(1'b0, 1'b1, 1'b1, 64'h0000_0000_0001_0000, 1'b1);
    cz(1'b0, 1'b0, 1'b0, 64'h0000_0000_0000_0001, 1'b0);
    $display("test count zero done");
    {long_mode, addr_prefix, code_32, fwd_count_valid} = 4'h8;
    load(64'h2);
    lp(BCL_OP_LOOP, 1'b0, 64'h1, 1'b1);
    lp(BCL_OP_LOOP, 1'b0, 64'h0, 1'b0);
    lp(BCL_OP_LOOP, 1'b0, 64'hFFFF_FFFF_FFFF_FFFF, 1'b1);
    addr_prefix = 1'b1;
    load(64'hAAAA_AAAA_0000_0000);
    lp(BCL_OP_LOOP, 1'b0, 64'hAAAA_AAAA_FFFF_FFFF, 1'b1);
    addr_prefix = 1'b0;
    load(64'h5);
    lp(BCL_OP_LOOP_EQ, 1'b1, 64'h4, 1'b1);
    lp(BCL_OP_LOOP_EQ, 1'b0, 64'h3, 1'b0);
    lp(BCL_OP_LOOP_NE, 1'b0, 64'h2, 1'b1);
    lp(BCL_OP_LOOP_NE, 1'b1, 64'h1, 1'b0);
    lp(BCL_OP_LOOP_EQ, 1'b1, 64'h0, 1'b0);
    long_mode = 1'b0;
    load(64'h0000_0000_0001_0000);
    lp(BCL_OP_LOOP, 1'b0, 64'h0000_0000_0001_FFFF, 1'b1);
    $display("test loops done");
    older_pending = 1'b1;
    @(posedge sys_clk);
    #1 {br_valid, br_op} = {1'b1, BCL_OP_COND};
    #1 chk("stall", br_stall, 64'h1);
    @(posedge sys_clk);
    #1 chk("held", res_valid, 64'h0);
    older_pending = 1'b0;
    @(posedge sys_clk);
    #1 br_valid = 1'b0;
    chk("released", res_valid, 64'h1);
    $display("test stall done");
    give_verdict();
  end
  initial begin
    #150000;
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
